// [inc/tpadc_consts.svh]
// Constants for the triple pipelined converter digital path.
`ifndef TPADC_CONSTS_SVH
`define TPADC_CONSTS_SVH
`define TPADC_NCH        3
`define TPADC_NSTAGE     6
`define TPADC_RES_W      10
`define TPADC_DIG_W      12
`define TPADC_DW         8
`define TPADC_SUM_W      9
`define TPADC_LO_TH      10'h0180
`define TPADC_HI_TH      10'h0280
`define TPADC_HALF       11'h0200
`define TPADC_FULL       11'h0400
`define TPADC_SAT_MAX    9'h00FF
`define TPADC_PH_SAMPLE  1'b0
`define TPADC_PH_HOLD    1'b1
`define TPADC_LAT_CYC    5
`define TPADC_PU_CYC     5'h0014
`define TPADC_PU_W       5
`define TPADC_CLK_NS     50
`endif

// [inc/tpadc_pkg.sv]
// Types shared by the converter digital path.
`include "tpadc_consts.svh"
package tpadc_pkg;
    typedef struct packed {
        logic [`TPADC_RES_W-1:0] residue;
        logic [`TPADC_DIG_W-1:0] digits;
    } tpadc_stage_type;

    typedef enum logic {
        PU_WAIT,
        PU_RUN
    } tpadc_pu_type;
endpackage : tpadc_pkg

// [hw/tpadc_stage.sv]
// One two-bit pipeline subconverter stage with its slice of the delay line.
`timescale 1ns/1ps
`include "tpadc_consts.svh"
module tpadc_stage
    import tpadc_pkg::*;
#(
    parameter int IDX = 0
) (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            arst_n,
    // Internal phase
    input  wire logic            phase_r,
    // Pipeline data
    input  wire tpadc_stage_type stg_in,
    output tpadc_stage_type      stg_r
);
    localparam logic PAR = ((IDX + 1) % 2) == 1;

    logic [1:0]              dig;
    logic [`TPADC_RES_W:0]   twice;
    logic [`TPADC_RES_W:0]   res_nxt;

    always_comb begin
        twice = {stg_in.residue, 1'b0};
        if (stg_in.residue < `TPADC_LO_TH) begin
            dig     = 2'h0;
            res_nxt = twice;
        end else if (stg_in.residue < `TPADC_HI_TH) begin
            dig     = 2'h1;
            res_nxt = twice - `TPADC_HALF;
        end else begin
            dig     = 2'h2;
            res_nxt = twice - `TPADC_FULL;
        end
    end

    // Adjacent stages see opposite phases, so one samples while the other amplifies.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stg_r <= '0;
        end else if (phase_r == PAR) begin
            stg_r.residue <= res_nxt[`TPADC_RES_W-1:0];
            stg_r.digits  <= stg_in.digits;
            stg_r.digits[`TPADC_DIG_W-1-2*IDX -: 2] <= dig;
        end
    end
endmodule : tpadc_stage

// [hw/tpadc_out.sv]
// Error correction, output coding and double output register for one channel.
`timescale 1ns/1ps
`include "tpadc_consts.svh"
module tpadc_out
    import tpadc_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   arst_n,
    // Internal phase and format
    input  wire logic                   phase_r,
    input  wire logic                   fmt_twos,
    // Aligned stage results
    input  wire logic [`TPADC_DIG_W-1:0] digits,
    input  wire logic [1:0]             flash,
    // Output word
    output logic [`TPADC_DW-1:0]        data_r
);
    logic [`TPADC_SUM_W-1:0] sum;
    logic [`TPADC_DW-1:0]    code;
    logic [`TPADC_DW-1:0]    corr_r;
    logic [`TPADC_DW-1:0]    ret_r;

    // Overlapping digit weights absorb comparator errors of each stage.
    always_comb begin
        sum = {{(`TPADC_SUM_W-2){1'b0}}, flash};
        for (int i = 0; i < `TPADC_NSTAGE; i++) begin
            sum = sum + (`TPADC_SUM_W'(digits[`TPADC_DIG_W-1-2*i -: 2]) << (6 - i));
        end
        code = (sum > `TPADC_SAT_MAX) ? `TPADC_DW'(`TPADC_SAT_MAX) : sum[`TPADC_DW-1:0];
        code[`TPADC_DW-1] = code[`TPADC_DW-1] ^ fmt_twos;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            corr_r <= '0;
        end else if (phase_r == `TPADC_PH_SAMPLE) begin
            corr_r <= code;
        end
    end

    // Two retiming stages keep the pins clean of correction-logic glitches.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ret_r  <= '0;
            data_r <= '0;
        end else if (phase_r == `TPADC_PH_HOLD) begin
            ret_r <= corr_r;
        end else begin
            data_r <= ret_r;
        end
    end
endmodule : tpadc_out

// [hw/tpadc_top.sv]
// Digital timing and output path of the three-channel pipelined converter.
`timescale 1ns/1ps
`include "tpadc_consts.svh"

module tpadc_top
    import tpadc_pkg::*;
(
    // Clock and reset
    input  wire logic                                  clk,
    input  wire logic                                  arst_n,
    // Held analog value per channel from the front end, same clock
    input  wire logic [`TPADC_NCH-1:0][`TPADC_RES_W-1:0] ana_hold,
    // Format select pin
    input  wire logic                                  output_format_select,
    // Output buses
    output logic [`TPADC_NCH-1:0][`TPADC_DW-1:0]       data_out,
    output logic                                       data_valid_r,
    output logic                                       smp_clk_out_r
);
    logic                                    phase_r;
    logic                                    fmt_s1_r;
    logic                                    fmt_s2_r;
    logic [`TPADC_PU_W-1:0]                  pu_cnt_r;
    tpadc_pu_type                            pu_state_r;
    tpadc_stage_type [`TPADC_NCH-1:0]        sh_r;
    tpadc_stage_type [`TPADC_NCH-1:0][`TPADC_NSTAGE-1:0] stg;
    logic [`TPADC_NCH-1:0][`TPADC_DIG_W-1:0] fl_dig_r;
    logic [`TPADC_NCH-1:0][1:0]              fl_val_r;

    // The master clock is divided into two phases; each sample clock spans two edges.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_r <= `TPADC_PH_SAMPLE;
        end else begin
            phase_r <= ~phase_r;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            smp_clk_out_r <= 1'b0;
        end else begin
            smp_clk_out_r <= phase_r;
        end
    end

    // The pin is asynchronous to the converter, so it is synchronised first.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fmt_s1_r <= 1'b0;
            fmt_s2_r <= 1'b0;
        end else begin
            fmt_s1_r <= output_format_select;
            fmt_s2_r <= fmt_s1_r;
        end
    end

    // Power-up settling: words are flagged invalid until enough samples have passed.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pu_cnt_r   <= '0;
            pu_state_r <= PU_WAIT;
        end else begin
            case (pu_state_r)
                PU_WAIT: begin
                    if (phase_r == `TPADC_PH_SAMPLE) begin
                        pu_cnt_r <= pu_cnt_r + `TPADC_PU_W'(1);
                        if (pu_cnt_r == `TPADC_PU_CYC - `TPADC_PU_W'(1)) begin
                            pu_state_r <= PU_RUN;
                        end
                    end
                end
                PU_RUN: begin
                    pu_state_r <= PU_RUN;
                end
                default: begin
                    pu_state_r <= PU_WAIT;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data_valid_r <= 1'b0;
        end else begin
            data_valid_r <= (pu_state_r == PU_RUN);
        end
    end

    genvar c;
    genvar s;
    generate
        for (c = 0; c < `TPADC_NCH; c++) begin : g_ch
            // Sample at the close of the sampling phase; held through the next.
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    sh_r[c] <= '0;
                end else if (phase_r == `TPADC_PH_SAMPLE) begin
                    sh_r[c].residue <= ana_hold[c];
                    sh_r[c].digits  <= '0;
                end
            end

            for (s = 0; s < `TPADC_NSTAGE; s++) begin : g_stg
                tpadc_stage #(
                    .IDX (s)
                ) u_stage (
                    .clk     (clk),
                    .arst_n  (arst_n),
                    .phase_r (phase_r),
                    .stg_in  ((s == 0) ? sh_r[c] : stg[c][(s == 0) ? 0 : s-1]),
                    .stg_r   (stg[c][s])
                );
            end

            // Final flash resolves the last residue; the delay line arrives alongside it.
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    fl_dig_r[c] <= '0;
                    fl_val_r[c] <= '0;
                end else if (phase_r == `TPADC_PH_HOLD) begin
                    fl_val_r[c] <= stg[c][`TPADC_NSTAGE-1].residue[`TPADC_RES_W-1 -: 2];
                    fl_dig_r[c] <= stg[c][`TPADC_NSTAGE-1].digits;
                end
            end

            tpadc_out u_out (
                .clk      (clk),
                .arst_n   (arst_n),
                .phase_r  (phase_r),
                .fmt_twos (fmt_s2_r),
                .digits   (fl_dig_r[c]),
                .flash    (fl_val_r[c]),
                .data_r   (data_out[c])
            );
        end
    endgenerate

    // Checks of the timing and coding of the path.
    // The first edge after reset has no earlier running phase to compare with.
    chk_phase_alt: assert property (@(posedge clk) disable iff (!arst_n)
        $past(arst_n) |-> (phase_r != $past(phase_r)))
        else $error("Internal phase failed to alternate.");

    chk_sample_edge: assert property (@(posedge clk) disable iff (!arst_n)
        (phase_r == `TPADC_PH_SAMPLE) |=> (sh_r[0].residue == $past(ana_hold[0])))
        else $error("Sample not taken at end of sampling phase.");

    chk_hold_stable: assert property (@(posedge clk) disable iff (!arst_n)
        (phase_r == `TPADC_PH_HOLD) |=> $stable(sh_r[1]))
        else $error("Held value changed during hold phase.");

    chk_stage_alt: assert property (@(posedge clk) disable iff (!arst_n)
        (phase_r == `TPADC_PH_SAMPLE) |=> ($stable(stg[2][0]) && $stable(stg[2][2])))
        else $error("Even stage changed in the wrong phase.");

    chk_stage_odd: assert property (@(posedge clk) disable iff (!arst_n)
        (phase_r == `TPADC_PH_HOLD) |=> ($stable(stg[2][1]) && $stable(stg[2][5])))
        else $error("Odd stage changed in the wrong phase.");

    chk_delay_line: assert property (@(posedge clk) disable iff (!arst_n)
        (phase_r == `TPADC_PH_HOLD) |=> (fl_dig_r[1] == $past(stg[1][5].digits)))
        else $error("Delay line lost alignment with the flash stage.");

    chk_zero_lat: assert property (@(posedge clk) disable iff (!arst_n)
        (phase_r == `TPADC_PH_SAMPLE && ana_hold[0] == '0 && !fmt_s2_r)
        ##1 (!fmt_s2_r) [*8] |-> ##3 (data_out[0] == 8'h00))
        else $error("Zero input not coded as offset zero after five samples.");

    chk_full_lat: assert property (@(posedge clk) disable iff (!arst_n)
        (phase_r == `TPADC_PH_SAMPLE && ana_hold[2] == 10'h03FF)
        |-> ##11 (data_out[2][6:0] == 7'h7F))
        else $error("Full scale input not saturated after five samples.");

    chk_twos_code: assert property (@(posedge clk) disable iff (!arst_n)
        (phase_r == `TPADC_PH_SAMPLE && ana_hold[1] == '0 && fmt_s2_r)
        ##1 (fmt_s2_r) [*8] |-> ##3 (data_out[1] == 8'h80))
        else $error("Two's complement coding of zero input is wrong.");

    chk_chan_same: assert property (@(posedge clk) disable iff (!arst_n)
        (phase_r == `TPADC_PH_SAMPLE && ana_hold[0] == ana_hold[1])
        |-> ##11 (data_out[0] == data_out[1]))
        else $error("Identical channels produced different words.");

    chk_out_cadence: assert property (@(posedge clk) disable iff (!arst_n)
        (phase_r == `TPADC_PH_HOLD) |=> $stable(data_out))
        else $error("Output word changed between sample clocks.");

    chk_valid_wait: assert property (@(posedge clk) disable iff (!arst_n)
        (pu_cnt_r < `TPADC_PU_CYC) |-> !data_valid_r)
        else $error("Data flagged valid before power-up settling.");

    chk_valid_stay: assert property (@(posedge clk) disable iff (!arst_n)
        data_valid_r |=> data_valid_r)
        else $error("Valid flag dropped after settling.");

    cov_valid: cover property (@(posedge clk) disable iff (!arst_n) $rose(data_valid_r));
    cov_twos: cover property (@(posedge clk) disable iff (!arst_n)
        fmt_s2_r && data_valid_r && data_out[0] == 8'h80);
    cov_full: cover property (@(posedge clk) disable iff (!arst_n)
        data_valid_r && data_out[2] == 8'hFF);
    cov_mid: cover property (@(posedge clk) disable iff (!arst_n)
        data_valid_r && stg[0][0].digits[`TPADC_DIG_W-1 -: 2] == 2'h1);
endmodule : tpadc_top

// [testbench/tpadc_capture.sv]
// Partner model: capture logic that registers all three output buses on the sample clock.
`timescale 1ns/1ps
`include "tpadc_consts.svh"
module tpadc_capture
    import tpadc_pkg::*;
(
    // Clock and reset
    input  wire logic                                  clk,
    input  wire logic                                  arst_n,
    // Converter output buses
    input  wire logic [`TPADC_NCH-1:0][`TPADC_DW-1:0] data_in,
    // Captured words and the sample index they belong to
    output logic [`TPADC_NCH-1:0][`TPADC_DW-1:0]      cap_word,
    output int                                         cap_idx,
    output logic                                       cap_vld
);
    int ecnt;

    // Edges are counted from the first edge after reset, which takes sample zero.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ecnt <= 0;
        end else begin
            ecnt <= ecnt + 1;
        end
    end

    // Words are taken on odd edges, mid-way through their two-cycle window, so setup never bites.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cap_word <= '0;
            cap_idx  <= 0;
            cap_vld  <= 1'h0;
        end else if ((ecnt % 2 == 1) && (ecnt >= 2 * `TPADC_LAT_CYC + 1)) begin
            cap_word <= data_in;
            cap_idx  <= (ecnt - 2 * `TPADC_LAT_CYC - 1) / 2;
            cap_vld  <= 1'h1;
        end
    end
endmodule : tpadc_capture

// [testbench/tb_top.sv]
// Self-checking bench for the three-channel converter digital path.
`timescale 1ns/1ps
`include "tpadc_consts.svh"
module tb_top
    import tpadc_pkg::*;
;
    logic                                  clk;
    logic                                  arst_n;
    logic [`TPADC_NCH-1:0][`TPADC_RES_W-1:0] ana_hold;
    logic                                  output_format_select;
    logic [`TPADC_NCH-1:0][`TPADC_DW-1:0]    data_out;
    logic                                  data_valid_r;
    logic                                  smp_clk_out_r;
    logic [`TPADC_NCH-1:0][`TPADC_DW-1:0]    cap_word;
    int                                    cap_idx;
    logic                                  cap_vld;
    int                                    edge_n;
    int                                    cycles;
    int                                    mismatches;
    int                                    check_count;
    logic [`TPADC_RES_W-1:0]               vals [8] = '{10'h000, 10'h3FF, 10'h200, 10'h1FF,
                                                        10'h004, 10'h3FC, 10'h100, 10'h300};

    tpadc_top u_tpadc_top (.clk(clk), .arst_n(arst_n), .ana_hold(ana_hold),
        .output_format_select(output_format_select), .data_out(data_out),
        .data_valid_r(data_valid_r), .smp_clk_out_r(smp_clk_out_r));

    tpadc_capture u_tpadc_capture (.clk(clk), .arst_n(arst_n), .data_in(data_out),
        .cap_word(cap_word), .cap_idx(cap_idx), .cap_vld(cap_vld));

    always #(`TPADC_CLK_NS / 2) clk = ~clk;

    // Edge index since reset release; at a falling edge it names the next rising edge.
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            edge_n <= 0;
        end else begin
            edge_n <= edge_n + 1;
        end
    end

    // A hang costs a mismatch; the whole run needs well under a thousand cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic expect8(input logic [7:0] got, input logic [7:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : expect8

    task automatic expect1(input logic got, input logic exp, input string m);
        expect8({7'h00, got}, {7'h00, exp}, m);
    endtask : expect1

    // Offset binary is the top eight bits of the held value; the other format flips the top bit.
    function automatic logic [7:0] code(input logic [`TPADC_RES_W-1:0] x, input logic f);
        code = x[9:2] ^ (f ? 8'h80 : 8'h00);
    endfunction : code

    task automatic do_reset();
        @(negedge clk);
        arst_n = 1'h0;
        repeat (6) @(negedge clk);
        expect8(data_out[0] | data_out[1] | data_out[2], 8'h00, "bus in reset");
        expect1(data_valid_r, 1'h0, "valid in reset");
        arst_n = 1'h1;
    endtask : do_reset

    task automatic t_power_up();
        logic prev;
        prev = smp_clk_out_r;
        while (edge_n < 40) begin
            @(negedge clk);
            if (edge_n > 1) expect1(smp_clk_out_r, ~prev, "clock out toggle");
            prev = smp_clk_out_r;
            if (edge_n == 39) expect1(data_valid_r, 1'h0, "valid too early");
        end
        expect1(data_valid_r, 1'h1, "valid after twenty samples");
    endtask : t_power_up

    // Streams n+7 samples back to back, junk on the holding half, and checks the first n words.
    task automatic t_stream(input logic f, input int n);
        int base;
        int got;
        int last;
        int k;
        output_format_select = f;
        repeat (6) @(negedge clk);
        while (edge_n % 2 != 0) @(negedge clk);
        base = edge_n / 2;
        got = 0;
        last = -1;
        for (int i = 0; i < n + 7; i++) begin
            for (int c = 0; c < `TPADC_NCH; c++) ana_hold[c] = vals[(i + c) % n];
            @(negedge clk);
            ana_hold = ~ana_hold;
            @(negedge clk);
            if (cap_vld && cap_idx != last && cap_idx >= base && cap_idx < base + n) begin
                k = cap_idx - base;
                last = cap_idx;
                got++;
                for (int c = 0; c < `TPADC_NCH; c++) begin
                    expect8(cap_word[c], code(vals[(k + c) % n], f), "channel word");
                end
            end
        end
        expect1(got == n, 1'h1, "word count in stream");
    endtask : t_stream

    initial begin
        clk = 1'h0;
        arst_n = 1'h0;
        ana_hold = '0;
        output_format_select = 1'h0;
        cycles = 0;
        mismatches = 0;
        check_count = 0;
        do_reset();
        t_power_up();
        t_stream(1'h0, 8);
        t_stream(1'h1, 8);
        t_stream(1'h0, 5);
        do_reset();
        t_stream(1'h1, 4);
        conclude();
    end
endmodule : tb_top
